/* pkg/tmz_regs.vh */
// Purpose: register map, field positions, reset values and counts of the 8-bit timer block
// Assumes: AHB-Lite word access; a printed offset is a register index, byte address = 4 * index
// Notes: definitions only
`ifndef TMZ_REGS_VH
`define TMZ_REGS_VH

// register indexes as printed, and their byte addresses
`define TMZ_IDX_COUNT 8'h01
`define TMZ_IDX_INTCTL 8'h0b
`define TMZ_IDX_OPTION 8'h81
`define TMZ_IDX_WDCMD 8'h90
`define TMZ_ADDR_COUNT 12'h004
`define TMZ_ADDR_INTCTL 12'h02c
`define TMZ_ADDR_OPTION 12'h204
`define TMZ_ADDR_WDCMD 12'h240
`define TMZ_ADDR_W 12

// timer_option_control fields
`define TMZ_OPT_PULLUP_DIS 7
`define TMZ_OPT_EXT_INT_EDGE 6
`define TMZ_OPT_CLK_SRC 5
`define TMZ_OPT_EDGE_SEL 4
`define TMZ_OPT_PRE_ASSIGN 3
`define TMZ_OPT_RATE_HI 2
`define TMZ_OPT_RATE_LO 0
`define TMZ_OPT_RESET 8'hff

// interrupt_control_register fields kept by this block
`define TMZ_INT_OVF_EN 5
`define TMZ_INT_OVF_FLAG 2
`define TMZ_INTCTL_RESET 8'h00

// watchdog command register field
`define TMZ_WDCMD_CLEAR 0

`define TMZ_COUNT_RESET 8'h00

// timing counts in core clocks / instruction cycles
`define TMZ_PHASES 2'h3
`define TMZ_PHASE_Q2 2'h1
`define TMZ_PHASE_Q4 2'h3
`define TMZ_WRITE_HOLD 2'h2

`endif

/* src/tmz_prescaler.v */
// Purpose: shared 8-bit prescaler, divides timer events or watchdog base ticks
// Assumes: all inputs on the core clock, events one cycle wide
// Notes: outputs are combinational pulses in the cycle of the dividing event
`timescale 1ns/100ps
module tmz_prescaler (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_tmr_evt,
   input wire i_wdt_evt,
   input wire i_clr,
   input wire [2:0] i_rate,
   input wire i_to_wdt,
   output wire o_tmr_tick,
   output wire o_wdt_tick
);

   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   wire evt;
   wire [3:0] tmr_bits;

   // ones in the low n bits; a carry out of those bits ends one division period
   function [7:0] low_mask;
      input [3:0] n;
      begin
         low_mask = (8'h01 << n) - 8'h01;
      end
   endfunction

   assign evt = i_to_wdt ? i_wdt_evt : i_tmr_evt;
   assign tmr_bits = {1'b0, i_rate} + 4'h1;

   always @* begin
      nxt_cnt = cnt_ff;
      if (i_clr) begin
         nxt_cnt = 8'h00;
      end else if (evt) begin
         nxt_cnt = cnt_ff + 8'h01;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt; // count never visible to software
      end
   end

   // timer division 1:2 .. 1:256
   assign o_tmr_tick = !i_to_wdt && i_tmr_evt && !i_clr &&
                       ((cnt_ff & low_mask(tmr_bits)) == low_mask(tmr_bits));
   // watchdog division 1:1 .. 1:128
   assign o_wdt_tick = i_to_wdt && i_wdt_evt && !i_clr &&
                       ((cnt_ff & low_mask({1'b0, i_rate})) == low_mask({1'b0, i_rate}));

endmodule // tmz_prescaler

/* src/tmz_timer.v */
// Purpose: 8-bit timer/counter with overflow flag and prescaler shared with the watchdog
// Assumes: AHB-Lite slave, single word transfers; one instruction cycle = four core clocks
// Notes: watchdog itself lives outside; this block feeds its divided tick and clear pulse
`timescale 1ns/100ps
`include "tmz_regs.vh"

module tmz_timer (
   input wire I_CORE_CLK,
   input wire I_RST_N,
   input wire I_HSEL,
   input wire [31:0] I_HADDR,
   input wire [1:0] I_HTRANS,
   input wire I_HWRITE,
   input wire [2:0] I_HSIZE,
   input wire [31:0] I_HWDATA,
   input wire I_HREADY,
   input wire I_EXT_COUNT_PIN,
   input wire I_SLEEP,
   input wire I_WDT_BASE_TICK,
   output reg [31:0] O_HRDATA,
   output reg O_HREADYOUT,
   output reg O_HRESP,
   output reg O_OVF_IRQ,
   output reg O_WDT_TICK,
   output reg O_WDT_CLEAR
);

   // instruction phase: 0..3 = Q1..Q4
   reg [1:0] phase_ff;
   wire instr_tick;

   // pin synchroniser and phase sampler
   reg pin_meta_ff;
   reg pin_sync_ff;
   reg pin_smp_ff;
   reg pin_smp_old_ff;
   wire smp_phase;
   wire ext_edge;

   // registers
   reg [7:0] count_ff;
   reg [7:0] nxt_count;
   reg [7:0] option_ff;
   reg ovf_en_ff;
   reg ovf_flag_ff;
   reg nxt_flag;
   reg nxt_en;
   wire [7:0] intctl_rst;
   reg [1:0] hold_ff;
   reg [1:0] nxt_hold;

   // bus data phase state
   reg wr_pend_ff;
   reg [`TMZ_ADDR_W-1:0] wr_addr_ff;
   wire addr_take;
   wire wr_count;
   wire wr_intctl;
   wire wr_option;
   wire wr_wdcmd;
   wire wdt_clear_cmd;
   reg [7:0] rd_byte;

   // control decodes
   wire src_ext;
   wire edge_fall;
   wire to_wdt;
   wire [2:0] rate;
   wire src_evt;
   wire tmr_evt;
   wire pre_tmr_tick;
   wire pre_wdt_tick;
   wire pre_clr;
   wire cnt_step;

   assign src_ext = option_ff[`TMZ_OPT_CLK_SRC];
   assign edge_fall = option_ff[`TMZ_OPT_EDGE_SEL];
   assign to_wdt = option_ff[`TMZ_OPT_PRE_ASSIGN];
   assign rate = option_ff[`TMZ_OPT_RATE_HI:`TMZ_OPT_RATE_LO];
   assign intctl_rst = `TMZ_INTCTL_RESET;

   // instruction clock phases
   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   assign instr_tick = (phase_ff == `TMZ_PHASES);

   // two flops before anything looks at the pin
   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
      end else begin
         pin_meta_ff <= I_EXT_COUNT_PIN;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // sampling only on Q2 and Q4; pulses shorter than two phases may be missed
   assign smp_phase = (phase_ff == `TMZ_PHASE_Q2) || (phase_ff == `TMZ_PHASE_Q4);

   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         pin_smp_ff <= 1'b0;
         pin_smp_old_ff <= 1'b0;
      end else if (smp_phase) begin
         pin_smp_ff <= pin_sync_ff;
         pin_smp_old_ff <= pin_smp_ff;
      end
   end

   // edge seen between two consecutive phase samples; edge bit flips polarity
   assign ext_edge = ((pin_smp_ff ^ edge_fall) && !(pin_smp_old_ff ^ edge_fall)) &&
                     (phase_ff == `TMZ_PHASE_Q2 + 2'h1 || phase_ff == 2'h0);

   // one source event per instruction cycle, or per selected pin edge
   assign src_evt = src_ext ? ext_edge : instr_tick;
   // no source events during sleep, so no overflow can arise
   assign tmr_evt = src_evt && !I_SLEEP;

   // AHB-Lite address phase capture
   assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;

   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= {`TMZ_ADDR_W{1'b0}};
      end else begin
         wr_pend_ff <= addr_take && I_HWRITE;
         if (addr_take) begin
            wr_addr_ff <= I_HADDR[`TMZ_ADDR_W-1:0];
         end
      end
   end

   assign wr_count = wr_pend_ff && (wr_addr_ff == `TMZ_ADDR_COUNT);
   assign wr_intctl = wr_pend_ff && (wr_addr_ff == `TMZ_ADDR_INTCTL);
   assign wr_option = wr_pend_ff && (wr_addr_ff == `TMZ_ADDR_OPTION);
   assign wr_wdcmd = wr_pend_ff && (wr_addr_ff == `TMZ_ADDR_WDCMD);
   assign wdt_clear_cmd = wr_wdcmd && I_HWDATA[`TMZ_WDCMD_CLEAR];

   // prescaler clear on count writes (timer side) or watchdog clear (watchdog side)
   assign pre_clr = (wr_count && !to_wdt) || (wdt_clear_cmd && to_wdt);

   tmz_prescaler u_prescaler (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_tmr_evt(tmr_evt),
      .i_wdt_evt(I_WDT_BASE_TICK),
      .i_clr(pre_clr),
      .i_rate(rate),
      .i_to_wdt(to_wdt),
      .o_tmr_tick(pre_tmr_tick),
      .o_wdt_tick(pre_wdt_tick)
   );

   // undivided events when the prescaler serves the watchdog
   assign cnt_step = (to_wdt ? tmr_evt : pre_tmr_tick) && (hold_ff == 2'h0);

   // write hold counts down at each instruction cycle end
   always @* begin
      nxt_hold = hold_ff;
      if (wr_count) begin
         nxt_hold = `TMZ_WRITE_HOLD;
      end else if (instr_tick && hold_ff != 2'h0) begin
         nxt_hold = hold_ff - 2'h1;
      end
   end

   // count: a software write wins over a same-cycle increment
   always @* begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = I_HWDATA[7:0];
      end else if (cnt_step) begin
         nxt_count = count_ff + 8'h01;
      end
   end

   // flag: a wrap in the same cycle as a software clear keeps the flag set
   always @* begin
      nxt_flag = ovf_flag_ff;
      nxt_en = ovf_en_ff;
      if (wr_intctl) begin
         nxt_flag = I_HWDATA[`TMZ_INT_OVF_FLAG];
         nxt_en = I_HWDATA[`TMZ_INT_OVF_EN];
      end
      if (!wr_count && cnt_step && count_ff == 8'hff) begin
         nxt_flag = 1'b1;
      end
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         count_ff <= `TMZ_COUNT_RESET;
         hold_ff <= 2'h0;
         ovf_flag_ff <= intctl_rst[`TMZ_INT_OVF_FLAG];
         ovf_en_ff <= intctl_rst[`TMZ_INT_OVF_EN];
         option_ff <= `TMZ_OPT_RESET;
      end else begin
         count_ff <= nxt_count;
         hold_ff <= nxt_hold;
         ovf_flag_ff <= nxt_flag;
         ovf_en_ff <= nxt_en;
         // reassignment allowed at any time; safe switching is software's job
         if (wr_option) begin
            option_ff <= I_HWDATA[7:0];
         end
      end
   end

   // read mux, registered in the address phase so hrdata comes from a flop
   always @* begin
      rd_byte = 8'h00;
      case (I_HADDR[`TMZ_ADDR_W-1:0])
         `TMZ_ADDR_COUNT: begin
            rd_byte = count_ff;
         end
         `TMZ_ADDR_INTCTL: begin
            rd_byte = 8'h00;
            rd_byte[`TMZ_INT_OVF_EN] = ovf_en_ff;
            rd_byte[`TMZ_INT_OVF_FLAG] = ovf_flag_ff;
         end
         `TMZ_ADDR_OPTION: begin
            rd_byte = option_ff;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_HRDATA <= 32'h0000_0000;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         if (addr_take && !I_HWRITE) begin
            O_HRDATA <= {24'h00_0000, rd_byte};
         end
      end
   end

   // interrupt, watchdog tick and watchdog clear, each one flop late
   always @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_OVF_IRQ <= 1'b0;
         O_WDT_TICK <= 1'b0;
         O_WDT_CLEAR <= 1'b0;
      end else begin
         // next flag and next enable, so a masking write acts at its own edge
         O_OVF_IRQ <= nxt_flag && nxt_en;
         O_WDT_TICK <= pre_wdt_tick;
         O_WDT_CLEAR <= wdt_clear_cmd;
      end
   end

endmodule // tmz_timer

/* testbench/tmz_timer_chk.sv */
// Purpose: port checker of the timer block
// Assumes: a write lands at the edge ending its data phase
// Notes: bound to every tmz_timer below
`timescale 1ns/100ps
`include "tmz_regs.vh"
module tmz_timer_chk (
   input wire I_CORE_CLK,
   input wire I_RST_N,
   input wire I_HSEL,
   input wire [31:0] I_HADDR,
   input wire [1:0] I_HTRANS,
   input wire I_HWRITE,
   input wire [31:0] I_HWDATA,
   input wire I_HREADY,
   input wire I_SLEEP,
   input wire I_WDT_BASE_TICK,
   input wire [31:0] O_HRDATA,
   input wire O_HREADYOUT,
   input wire O_HRESP,
   input wire O_OVF_IRQ,
   input wire O_WDT_TICK,
   input wire O_WDT_CLEAR
);
   reg wr_ff;
   reg [11:0] adr_ff;
   wire wr_int;
   wire wr_wd;
   // data phase of a write, kept so assertions see its address
   always @(posedge I_CORE_CLK) begin
      wr_ff <= I_RST_N & I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE;
      adr_ff <= I_HADDR[11:0];
   end
   assign wr_int = wr_ff && adr_ff == `TMZ_ADDR_INTCTL;
   assign wr_wd = wr_ff && adr_ff == `TMZ_ADDR_WDCMD;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   ready_high_a: assert property (O_HREADYOUT) else $error("hreadyout low");
   resp_okay_a: assert property (!O_HRESP) else $error("hresp not okay");
   rdata_upper_a: assert property (O_HRDATA[31:8] == 24'h0) else $error("upper read bits set");
   irq_mask_a: assert property (wr_int && !I_HWDATA[5] |=> !O_OVF_IRQ)
      else $error("masked irq still high");
   flag_sticky_a: assert property (O_OVF_IRQ && !wr_int |=> O_OVF_IRQ)
      else $error("irq dropped without write");
   sleep_quiet_a: assert property ($rose(O_OVF_IRQ) |-> !$past(I_SLEEP) || $past(wr_int))
      else $error("overflow during sleep");
   tick_cause_a: assert property (O_WDT_TICK |-> $past(I_WDT_BASE_TICK))
      else $error("watchdog tick without base tick");
   clr_pulse_a: assert property (wr_wd && I_HWDATA[0] |=> O_WDT_CLEAR ##1 !O_WDT_CLEAR)
      else $error("watchdog clear pulse wrong");
   cover property (O_WDT_TICK);
   cover property ($rose(O_OVF_IRQ));
   cover property (O_WDT_CLEAR);
endmodule // tmz_timer_chk
bind tmz_timer tmz_timer_chk i_tmz_timer_chk (.I_CORE_CLK, .I_RST_N, .I_HSEL, .I_HADDR,
   .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .I_SLEEP, .I_WDT_BASE_TICK, .O_HRDATA,
   .O_HREADYOUT, .O_HRESP, .O_OVF_IRQ, .O_WDT_TICK, .O_WDT_CLEAR);

/* testbench/tmz_pin_src.sv */
// Purpose: external count source on the counter pin
// Assumes: pin idles low between bursts
// Notes: bursts are started by the bench
`timescale 1ns/100ps
module tmz_pin_src (
   input wire i_clk,
   output logic o_pin
);
   initial o_pin = 1'b0;
   task automatic burst(input int toggles, input int half);
      repeat (toggles) begin
         repeat (half < 2 ? 2 : half) @(posedge i_clk);
         o_pin <= ~o_pin;
      end
   endtask
   task idle;
      @(posedge i_clk);
      o_pin <= 1'b0;
   endtask
endmodule // tmz_pin_src

/* testbench/tb_top.sv */
// Purpose: self-checking bench of the timer block
// Assumes: zero-wait bus, instruction cycle of four clocks
// Notes: count deltas use fixed read spacing
`timescale 1ns/100ps
`include "tmz_regs.vh"
module tb_top;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sleep = 0, wbase = 0;
   logic [31:0] haddr = 0, hwdata = 0;
   logic [1:0] htrans = 0;
   wire [31:0] hrdata;
   wire hready, hresp, irq, wtick, wclr, pin;
   int errors = 0, checks_done = 0, cyc = 0, ticks = 0, n, h;
   logic [7:0] r0, r1, v;
   logic [11:0] ra[4] = '{`TMZ_ADDR_OPTION, `TMZ_ADDR_COUNT, `TMZ_ADDR_INTCTL, 12'h100};
   logic [7:0] rv[4] = '{`TMZ_OPT_RESET, `TMZ_COUNT_RESET, `TMZ_INTCTL_RESET, 8'h00};
   always #2 clk = ~clk;
   tmz_timer i_tmz_timer (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .I_EXT_COUNT_PIN(pin), .I_SLEEP(sleep), .I_WDT_BASE_TICK(wbase),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_OVF_IRQ(irq),
      .O_WDT_TICK(wtick), .O_WDT_CLEAR(wclr));
   tmz_pin_src i_tmz_pin_src (.i_clk(clk), .o_pin(pin));
   task final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wtick === 1'b1)
         ticks <= ticks + 1;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
         $display("Error %s expected %h seen %h", nm, e, g);
      if (g !== e)
         errors++;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata[7:0];
   endtask
   function automatic int tmr_div(input int r);
      return 2 << r;
   endfunction
   function automatic int exp_edges(input int k, input int es);
      return es ? k - 1 : k;
   endfunction
   // reads spaced p*k clocks apart must differ by k
   task delta(input int p, input int k, input string nm);
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r0);
      repeat (p * k - 3) @(posedge clk);
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r1);
      chk(nm, r0 + 8'(k), r1);
   endtask
   initial begin
      void'($urandom(59732));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, ra[i], 8'h0, r0);
         chk("reset value", rv[i], r0);
      end
      $display("test reset done");
      bus(1'b1, `TMZ_ADDR_OPTION, 8'h08, r0);
      delta(4, 5, "undivided count");
      bus(1'b1, `TMZ_ADDR_WDCMD, 8'h01, r0);
      for (int r = 0; r < 8; r++) begin
         bus(1'b1, `TMZ_ADDR_OPTION, {5'h0, 3'(r)}, r0);
         delta(4 * tmr_div(r), 2, "timer rate");
      end
      // rate 1:256 on the timer: a count write restarts the full division period
      v = 8'($urandom);
      bus(1'b1, `TMZ_ADDR_COUNT, v, r0);
      repeat (1000) @(posedge clk);
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r0);
      chk("count before prescaled tick", v, r0);
      repeat (24) @(posedge clk);
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r1);
      chk("count after prescaled tick", v + 8'h01, r1);
      $display("test rates done");
      bus(1'b1, `TMZ_ADDR_WDCMD, 8'h01, r0);
      bus(1'b1, `TMZ_ADDR_COUNT, 8'h00, r0);
      bus(1'b1, `TMZ_ADDR_OPTION, 8'h08, r0);
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         bus(1'b1, `TMZ_ADDR_COUNT, v, r0);
         bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r0);
         chk("count after write", v, r0);
      end
      bus(1'b1, `TMZ_ADDR_INTCTL, 8'h00, r0);
      bus(1'b1, `TMZ_ADDR_COUNT, 8'hfe, r0);
      repeat (40) @(posedge clk);
      chk("masked irq", 8'h0, {7'h0, irq});
      bus(1'b0, `TMZ_ADDR_INTCTL, 8'h0, r0);
      chk("flag on wrap", 8'h04, r0);
      bus(1'b1, `TMZ_ADDR_INTCTL, 8'h24, r0);
      repeat (40) @(posedge clk);
      chk("enabled irq", 8'h1, {7'h0, irq});
      bus(1'b1, `TMZ_ADDR_INTCTL, 8'h04, r0);
      #1 chk("masked pending irq", 8'h0, {7'h0, irq});
      bus(1'b1, `TMZ_ADDR_INTCTL, 8'h20, r0);
      #1 chk("cleared irq", 8'h0, {7'h0, irq});
      $display("test overflow done");
      @(posedge clk);
      sleep <= 1'b1;
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r0);
      repeat (37) @(posedge clk);
      bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r1);
      chk("sleep freeze", r0, r1);
      sleep <= 1'b0;
      for (int es = 0; es < 2; es++) begin
         bus(1'b1, `TMZ_ADDR_OPTION, es ? 8'h38 : 8'h28, r0);
         n = 3 + $urandom % 6;
         h = 2 + $urandom % 5;
         bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r0);
         i_tmz_pin_src.burst(2 * n - 1, h);
         repeat (20) @(posedge clk);
         bus(1'b0, `TMZ_ADDR_COUNT, 8'h0, r1);
         chk("pin edges", r0 + 8'(exp_edges(n, es)), r1);
         i_tmz_pin_src.idle();
         repeat (20) @(posedge clk);
      end
      $display("test pin done");
      for (int r = 0; r < 5; r++) begin
         bus(1'b1, `TMZ_ADDR_WDCMD, 8'h01, r0);
         bus(1'b1, `TMZ_ADDR_OPTION, r < 4 ? {5'h1, 3'(r)} : 8'h00, r0);
         bus(1'b1, `TMZ_ADDR_WDCMD, 8'h01, r0);
         #1 chk("watchdog clear", 8'h1, {7'h0, wclr});
         repeat (3) @(posedge clk);
         n = ticks;
         repeat (3 << (r % 4)) begin
            @(posedge clk);
            wbase <= 1'b1;
            @(posedge clk);
            wbase <= 1'b0;
            @(posedge clk);
         end
         repeat (3) @(posedge clk);
         chk("watchdog ticks", r < 4 ? 8'h3 : 8'h0, 8'(ticks - n));
      end
      $display("test watchdog done");
      final_report();
   end
endmodule // tb_top
